//--- src/pattern_output_control.sv
`timescale 1ns/1ps
module pattern_output_control
    import pattern_output_pkg::*;
#(
    parameter int BLINK_LEN = BLINK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        link_clk,
    input  wire logic        field_wr,
    input  wire field_sel_t  field_sel,
    input  wire logic [7:0]  field_value,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_ack,
    input  wire logic        bank_wr,
    input  wire logic [1:0]  bank_num,
    input  wire logic [4:0]  bank_value,
    output logic      [19:0] bank_delay,
    input  wire logic        play_buf_wr,
    input  wire logic [31:0] play_addr,
    input  wire logic [31:0] play_bytes,
    input  wire logic        play_cmd_valid,
    input  wire play_cmd_t   play_cmd,
    output play_cfg_t        play_out,
    input  wire logic        perr_latch_mode,
    input  wire logic        parity_error_link,
    input  wire logic        reset_button,
    output logic             perr_led,
    output logic      [2:0]  loop_control,
    output logic             data_clock_reset,
    output logic             transmit_receive_reset,
    output clk_cfg_t         clk_cfg,
    output mapper_cfg_t      mapper_cfg,
    output logic             sync_go_link
);

    // ****************************************
    // decode functions
    // ****************************************
    function automatic logic [31:0] field_mask(input field_sel_t s);
        logic [31:0] m;
        m = 32'h0000_0000;
        case (s)
            FLD_LOOP:     m[LOOP_LSB +: LOOP_W]     = '1;
            FLD_REFCLK:   m[REFCLK_LSB +: REFCLK_W] = '1;
            FLD_PINV:     m[PINV_BIT]               = 1'b1;
            FLD_PERR_ON:  m[PERR_ON_BIT]            = 1'b1;
            FLD_SWAP:     m[SWAP_LSB +: SWAP_W]     = '1;
            FLD_FB:       m[FB_BIT]                 = 1'b1;
            FLD_CDLY:     m[CDLY_LSB +: CDLY_W]     = '1;
            FLD_CDLY_EN:  m[CDLY_EN_BIT]            = 1'b1;
            FLD_DCLK_RST: m[DCLK_RST_BIT]           = 1'b1;
            FLD_TXRX_RST: m[TXRX_RST_BIT]           = 1'b1;
            FLD_GO:       m[GO_BIT]                 = 1'b1;
            FLD_DLL:      m[DLL_LSB +: DLL_W]       = '1;
            FLD_WSEL:     m[WSEL_BIT]               = 1'b1;
            default:      m = 32'h0000_0000;
        endcase
        return m;
    endfunction

    function automatic logic [4:0] field_lsb(input field_sel_t s);
        int l;
        l = 0;
        case (s)
            FLD_LOOP:     l = LOOP_LSB;
            FLD_REFCLK:   l = REFCLK_LSB;
            FLD_PINV:     l = PINV_BIT;
            FLD_PERR_ON:  l = PERR_ON_BIT;
            FLD_SWAP:     l = SWAP_LSB;
            FLD_FB:       l = FB_BIT;
            FLD_CDLY:     l = CDLY_LSB;
            FLD_CDLY_EN:  l = CDLY_EN_BIT;
            FLD_DCLK_RST: l = DCLK_RST_BIT;
            FLD_TXRX_RST: l = TXRX_RST_BIT;
            FLD_GO:       l = GO_BIT;
            FLD_DLL:      l = DLL_LSB;
            FLD_WSEL:     l = WSEL_BIT;
            default:      l = 0;
        endcase
        return l[4:0];
    endfunction

    function automatic swap_class_t swap_decode(input logic [5:0] c);
        swap_class_t r;
        r = SWAP_NONE;
        case (c)
            6'h01, 6'h02, 6'h03: r = SWAP_8;
            6'h04, 6'h08, 6'h0C: r = SWAP_32;
            6'h10, 6'h20, 6'h30: r = SWAP_128;
            default:             r = SWAP_NONE;
        endcase
        return r;
    endfunction

    function automatic refclk_src_t refclk_decode(input logic [1:0] c);
        refclk_src_t r;
        case (c)
            2'h1:    r = SRC_OSC;
            2'h3:    r = SRC_COAX;
            default: r = SRC_MEZZ;
        endcase
        return r;
    endfunction

    function automatic mux_mode_t mux_decode(input logic [2:0] c);
        mux_mode_t r;
        case (c)
            3'h1:                    r = MUX2_AC;
            3'h2:                    r = MUX2_BC;
            3'h4, 3'h5, 3'h6, 3'h7:  r = MUX4;
            default:                 r = MUX_OFF;
        endcase
        return r;
    endfunction

    // ****************************************
    // control word
    // ****************************************
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] fmask;
    logic [31:0] fval;

    always_comb begin
        ctrl_next = ctrl_reg;
        fmask = field_mask(field_sel);
        fval = {{24{1'b0}}, field_value} << field_lsb(field_sel);
        if (reg_wr && reg_addr == CTRL_ADDR) begin
            ctrl_next = reg_wdata;
        end
        if (field_wr) begin
            ctrl_next = (ctrl_next & ~fmask) | (fval & fmask);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************
    // field outputs
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_control           <= 3'h0;
            data_clock_reset       <= 1'b0;
            transmit_receive_reset <= 1'b0;
        end else if (ce) begin
            loop_control <= ctrl_reg[LOOP_LSB +: LOOP_W];
            data_clock_reset <= ctrl_reg[DCLK_RST_BIT];
            transmit_receive_reset <= ctrl_reg[TXRX_RST_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_cfg <= '0;
        end else if (ce) begin
            clk_cfg.ref_sel <= ctrl_reg[REFCLK_LSB +: REFCLK_W];
            clk_cfg.src <= refclk_decode(ctrl_reg[REFCLK_LSB +: REFCLK_W]);
            clk_cfg.feedback_en <= ctrl_reg[FB_BIT];
            clk_cfg.delay_en <= ctrl_reg[CDLY_EN_BIT];
            clk_cfg.delay_taps <= ctrl_reg[CDLY_LSB +: CDLY_W];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mapper_cfg <= '0;
        end else if (ce) begin
            mapper_cfg.parity_invert <= ctrl_reg[PINV_BIT];
            mapper_cfg.swap_sel <= ctrl_reg[SWAP_LSB +: SWAP_W];
            mapper_cfg.swap_class <= swap_decode(ctrl_reg[SWAP_LSB +: SWAP_W]);
            mapper_cfg.dll_disable <= ctrl_reg[DLL_LSB +: DLL_W];
            mapper_cfg.width_select <= ctrl_reg[WSEL_BIT];
            mapper_cfg.mux_mode <= mux_decode(ctrl_reg[31:29]);
            case (mux_decode(ctrl_reg[31:29]))
                MUX2_AC: mapper_cfg.lane_en <= 4'h5;
                MUX2_BC: mapper_cfg.lane_en <= 4'h6;
                MUX4:    mapper_cfg.lane_en <= 4'hF;
                default: mapper_cfg.lane_en <= 4'h0;
            endcase
        end
    end

    // ****************************************
    // bank output delays
    // ****************************************
    logic [4:0] bank_reg [NUM_BANKS];

    generate
        for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bank_reg[b] <= BANK_RESET[b*TAP_W +: TAP_W];
                end else if (ce) begin
                    if (bank_wr && bank_num == 2'(b)) begin
                        bank_reg[b] <= bank_value;
                    end else if (reg_wr && reg_addr == BANK_ADDR) begin
                        bank_reg[b] <= reg_wdata[b*TAP_W +: TAP_W];
                    end
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bank_delay[b*TAP_W +: TAP_W] <= BANK_RESET[b*TAP_W +: TAP_W];
                end else if (ce) begin
                    bank_delay[b*TAP_W +: TAP_W] <= bank_reg[b];
                end
            end
        end
    endgenerate

    // ****************************************
    // play channel
    // ****************************************
    play_state_t play_state;
    logic [31:0] play_base_reg;
    logic [31:0] play_len_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            play_state <= ST_IDLE;
        end else if (ce && play_cmd_valid) begin
            case (play_cmd)
                PLAY_START: play_state <= ST_RUN;
                PLAY_STOP:  play_state <= ST_IDLE;
                PLAY_RESET: play_state <= ST_IDLE;
                default:    play_state <= play_state;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            play_base_reg <= 32'h0000_0000;
            play_len_reg  <= 32'h0000_0000;
        end else if (ce && play_state == ST_IDLE) begin
            if (play_buf_wr) begin
                play_base_reg <= play_addr;
                play_len_reg  <= play_bytes;
            end else if (reg_wr && reg_addr == PLAY_BASE_ADDR) begin
                play_base_reg <= reg_wdata;
            end else if (reg_wr && reg_addr == PLAY_LEN_ADDR) begin
                play_len_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            play_out <= '0;
        end else if (ce) begin
            play_out.base   <= play_base_reg;
            play_out.length <= play_len_reg;
            play_out.run    <= (play_state == ST_RUN);
            play_out.reset  <= play_cmd_valid && play_cmd == PLAY_RESET;
        end
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [2:0] perr_sync;
    logic [2:0] btn_sync;
    logic       perr_q;
    logic       btn_q;
    logic       btn_prev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_sync <= 3'h0;
            btn_sync  <= 3'h0;
            perr_q    <= 1'b0;
            btn_q     <= 1'b0;
            btn_prev  <= 1'b0;
        end else if (ce) begin
            perr_sync <= {perr_sync[1:0], parity_error_link};
            btn_sync  <= {btn_sync[1:0], reset_button};
            if (perr_sync[1] == perr_sync[2]) begin
                perr_q <= perr_sync[2];
            end
            if (btn_sync[1] == btn_sync[2]) begin
                btn_q <= btn_sync[2];
            end
            btn_prev <= btn_q;
        end
    end

    // ****************************************
    // parity indicator
    // ****************************************
    logic        perr_latched;
    logic        blink_phase;
    logic [24:0] blink_cnt;
    logic        blink_active;

    assign blink_active = perr_latch_mode ? (perr_q | perr_latched) : 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_latched <= 1'b0;
        end else if (ce) begin
            if (perr_q) begin
                perr_latched <= 1'b1;
            end else if (btn_q && !btn_prev) begin
                perr_latched <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt   <= 25'h000_0000;
            blink_phase <= 1'b0;
        end else if (ce) begin
            if (!blink_active) begin
                blink_cnt   <= 25'h000_0000;
                blink_phase <= 1'b0;
            end else if (blink_cnt == 25'(BLINK_LEN - 1)) begin
                blink_cnt   <= 25'h000_0000;
                blink_phase <= ~blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 25'h000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_led <= 1'b0;
        end else if (ce) begin
            perr_led <= ctrl_reg[PERR_ON_BIT] & blink_active & blink_phase;
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack   <= 1'b0;
        end else if (ce) begin
            reg_ack <= reg_rd | reg_wr;
            if (reg_rd) begin
                case (reg_addr)
                    CTRL_ADDR:      reg_rdata <= ctrl_reg;
                    STATUS_ADDR:    reg_rdata <= {29'h0, perr_latched,
                                                  perr_q, play_state == ST_RUN};
                    BANK_ADDR:      reg_rdata <= {12'h000, bank_reg[3],
                                                  bank_reg[2], bank_reg[1],
                                                  bank_reg[0]};
                    PLAY_BASE_ADDR: reg_rdata <= play_base_reg;
                    PLAY_LEN_ADDR:  reg_rdata <= play_len_reg;
                    PLAY_STAT_ADDR: reg_rdata <= {31'h0, play_state == ST_RUN};
                    default:        reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // link clock domain: go trigger
    // ****************************************
    logic [2:0] go_sync;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            go_sync      <= 3'h0;
            sync_go_link <= 1'b0;
        end else begin
            go_sync <= {go_sync[1:0], ctrl_reg[GO_BIT]};
            if (go_sync[1] == go_sync[2]) begin
                sync_go_link <= go_sync[2];
            end
        end
    end

endmodule

//--- src/pattern_output_pkg.sv
package pattern_output_pkg;

    // ****************************************
    // control word field layout
    // ****************************************
    localparam int LOOP_LSB      = 0;
    localparam int LOOP_W        = 3;
    localparam int REFCLK_LSB    = 3;
    localparam int REFCLK_W      = 2;
    localparam int PINV_BIT      = 5;
    localparam int PERR_ON_BIT   = 6;
    localparam int SWAP_LSB      = 8;
    localparam int SWAP_W        = 6;
    localparam int FB_BIT        = 14;
    localparam int CDLY_LSB      = 15;
    localparam int CDLY_W        = 5;
    localparam int CDLY_EN_BIT   = 20;
    localparam int DCLK_RST_BIT  = 25;
    localparam int TXRX_RST_BIT  = 26;
    localparam int GO_BIT        = 27;
    localparam int DLL_LSB       = 29;
    localparam int DLL_W         = 2;
    localparam int WSEL_BIT      = 31;

    localparam logic [31:0] CTRL_RESET = 32'hE000_0000;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [31:0] CTRL_ADDR      = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR    = 32'h0000_0004;
    localparam logic [31:0] BANK_ADDR      = 32'h0000_0008;
    localparam logic [31:0] PLAY_BASE_ADDR = 32'h0000_000C;
    localparam logic [31:0] PLAY_LEN_ADDR  = 32'h0000_0010;
    localparam logic [31:0] PLAY_STAT_ADDR = 32'h0000_0014;

    // ****************************************
    // bank delays and timing
    // ****************************************
    localparam int          NUM_BANKS  = 4;
    localparam int          TAP_W      = 5;
    localparam logic [19:0] BANK_RESET = 20'h1_0400;
    localparam int          TAP_PS     = 78;
    localparam int          CLK_MHZ    = 100;
    localparam int          BLINK_MS   = 250;
    localparam int          BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        FLD_LOOP     = 4'b0000,
        FLD_REFCLK   = 4'b0001,
        FLD_PINV     = 4'b0010,
        FLD_PERR_ON  = 4'b0011,
        FLD_SWAP     = 4'b0100,
        FLD_FB       = 4'b0101,
        FLD_CDLY     = 4'b0110,
        FLD_CDLY_EN  = 4'b0111,
        FLD_DCLK_RST = 4'b1000,
        FLD_TXRX_RST = 4'b1001,
        FLD_GO       = 4'b1010,
        FLD_DLL      = 4'b1011,
        FLD_WSEL     = 4'b1100
    } field_sel_t;

    typedef enum logic [1:0] {
        SRC_MEZZ = 2'b00,
        SRC_OSC  = 2'b01,
        SRC_COAX = 2'b11
    } refclk_src_t;

    typedef enum logic [1:0] {
        SWAP_NONE = 2'b00,
        SWAP_8    = 2'b01,
        SWAP_32   = 2'b10,
        SWAP_128  = 2'b11
    } swap_class_t;

    typedef enum logic [1:0] {
        MUX_OFF    = 2'b00,
        MUX2_AC    = 2'b01,
        MUX2_BC    = 2'b10,
        MUX4       = 2'b11
    } mux_mode_t;

    typedef enum logic [1:0] {
        PLAY_NOP   = 2'b00,
        PLAY_START = 2'b01,
        PLAY_STOP  = 2'b10,
        PLAY_RESET = 2'b11
    } play_cmd_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } play_state_t;

    typedef struct packed {
        logic [1:0]  ref_sel;
        refclk_src_t src;
        logic        feedback_en;
        logic        delay_en;
        logic [4:0]  delay_taps;
    } clk_cfg_t;

    typedef struct packed {
        logic        parity_invert;
        logic [5:0]  swap_sel;
        swap_class_t swap_class;
        logic [1:0]  dll_disable;
        logic        width_select;
        mux_mode_t   mux_mode;
        logic [3:0]  lane_en;
    } mapper_cfg_t;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] length;
        logic        run;
        logic        reset;
    } play_cfg_t;

endpackage

//--- tb/dac_link_model.sv
`timescale 1ns/1ps
module dac_link_model (
    input  wire logic run,
    input  wire logic perr_cmd,
    output logic      link_clk,
    output logic      parity_error_link
);
    // ****************************************
    // data clock and parity flag of dac board
    // ****************************************
    initial begin
        link_clk = 1'b0;
        parity_error_link = 1'b0;
        #7;
        forever #16 link_clk = run ? ~link_clk : 1'b0;
    end
    always @(posedge link_clk) begin
        parity_error_link <= perr_cmd;
    end
endmodule

//--- tb/pattern_output_control_properties.sv
`timescale 1ns/1ps
module pattern_output_control_properties
    import pattern_output_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        field_wr,
    input wire field_sel_t  field_sel,
    input wire logic [7:0]  field_value,
    input wire logic        reg_wr,
    input wire logic        bank_wr,
    input wire logic [1:0]  bank_num,
    input wire logic [4:0]  bank_value,
    input wire logic [19:0] bank_delay,
    input wire logic        play_cmd_valid,
    input wire play_cmd_t   play_cmd,
    input wire play_cfg_t   play_out,
    input wire logic [2:0]  loop_control,
    input wire logic        data_clock_reset,
    input wire clk_cfg_t    clk_cfg,
    input wire mapper_cfg_t mapper_cfg
);
    // ****************************************
    // control field, bank delay and play reset checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic fw = ce && field_wr && !reg_wr;

    chk_loop_field: assert property (fw && field_sel == FLD_LOOP |->
        ##2 loop_control == $past(field_value[2:0], 2))
        else $error("loop field not applied");
    chk_other_hold: assert property (fw && field_sel != FLD_LOOP |->
        ##2 $stable(loop_control)) else $error("loop field disturbed");
    chk_dclk_field: assert property (fw && field_sel == FLD_DCLK_RST
        |-> ##2 data_clock_reset == $past(field_value[0], 2))
        else $error("data clock reset wrong");
    chk_fb_field: assert property (fw && field_sel == FLD_FB |->
        ##2 clk_cfg.feedback_en == $past(field_value[0], 2))
        else $error("feedback enable wrong");
    chk_bank_write: assert property (ce && bank_wr |-> ##2
        bank_delay[5 * $past(bank_num, 2) +: 5] == $past(bank_value, 2))
        else $error("bank tap count wrong");
    chk_swap_class: assert property (
        mapper_cfg.swap_sel inside {6'd4, 6'd8, 6'd12}
        |-> mapper_cfg.swap_class == SWAP_32) else $error("swap class wrong");
    chk_mux_mode: assert property (
        {mapper_cfg.width_select, mapper_cfg.dll_disable} == 3'd1
        |-> mapper_cfg.mux_mode == MUX2_AC && mapper_cfg.lane_en == 4'h5)
        else $error("two lane mode wrong");
    chk_src_coax: assert property (clk_cfg.ref_sel == 2'b11
        |-> clk_cfg.src == SRC_COAX) else $error("coax source wrong");
    chk_play_reset: assert property (
        ce && play_cmd_valid && play_cmd == PLAY_RESET |=> play_out.reset
        ##1 (!play_out.reset && !play_out.run)) else $error("play reset wrong");
endmodule

bind pattern_output_control pattern_output_control_properties
    u_pattern_output_control_properties (
    .clk(clk), .rst_n(rst_n), .ce(ce), .field_wr(field_wr),
    .field_sel(field_sel), .field_value(field_value), .reg_wr(reg_wr),
    .bank_wr(bank_wr), .bank_num(bank_num), .bank_value(bank_value),
    .bank_delay(bank_delay), .play_cmd_valid(play_cmd_valid),
    .play_cmd(play_cmd), .play_out(play_out), .loop_control(loop_control),
    .data_clock_reset(data_clock_reset), .clk_cfg(clk_cfg),
    .mapper_cfg(mapper_cfg));

//--- tb/pattern_output_control_tb.sv
`timescale 1ns/1ps
module pattern_output_control_tb
    import pattern_output_pkg::*;
;
    logic        clk = 0, rst_n = 0, pmode = 1, perr_cmd = 0;
    logic        field_wr = 0, reg_wr = 0, reg_rd = 0, bank_wr = 0;
    logic        play_buf_wr = 0, play_cmd_valid = 0, reset_button = 0;
    field_sel_t  field_sel = FLD_LOOP;
    play_cmd_t   play_cmd = PLAY_NOP;
    logic [7:0]  field_value = 0;
    logic [31:0] reg_addr = 0, reg_wdata = 0, play_addr = 0, play_bytes = 0;
    logic [1:0]  bank_num = 0;
    logic [4:0]  bank_value = 0;
    logic [31:0] reg_rdata, rd, exp, m;
    logic        reg_ack, perr_led, dclk_rst, txrx_rst, go, link_clk, perr;
    logic [19:0] bank_delay;
    logic [2:0]  loop_control;
    play_cfg_t   play_out;
    clk_cfg_t    clk_cfg;
    mapper_cfg_t mapper_cfg;
    int          err_count = 0, n_tests = 0, n;
    int          lsb[13] = '{0, 3, 5, 6, 8, 14, 15, 20, 25, 26, 27, 29, 31};
    int          wid[13] = '{3, 2, 1, 1, 6, 1, 5, 1, 1, 1, 1, 2, 1};
    int          sw[11] = '{0, 1, 2, 3, 4, 8, 12, 16, 32, 48, 5};

    pattern_output_control #(.BLINK_LEN(4)) u_pattern_output_control (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .link_clk(link_clk),
        .field_wr(field_wr), .field_sel(field_sel), .field_value(field_value),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .bank_wr(bank_wr), .bank_num(bank_num), .bank_value(bank_value),
        .bank_delay(bank_delay), .play_buf_wr(play_buf_wr),
        .play_addr(play_addr), .play_bytes(play_bytes),
        .play_cmd_valid(play_cmd_valid), .play_cmd(play_cmd),
        .play_out(play_out), .perr_latch_mode(pmode),
        .parity_error_link(perr), .reset_button(reset_button),
        .perr_led(perr_led), .loop_control(loop_control),
        .data_clock_reset(dclk_rst), .transmit_receive_reset(txrx_rst),
        .clk_cfg(clk_cfg), .mapper_cfg(mapper_cfg), .sync_go_link(go));
    dac_link_model u_dac_link_model (.run(1'b1), .perr_cmd(perr_cmd),
        .link_clk(link_clk), .parity_error_link(perr));

    // ****************************************
    // access tasks
    // ****************************************
    initial forever #5 clk = ~clk;
    task automatic step(int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic access(logic wr, logic [31:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
        reg_rd <= 0;
        repeat (8) begin
            @(posedge clk);
            if (reg_ack === 1'b1) break;
        end
        rd = (reg_ack === 1'b1) ? reg_rdata : 'x;
    endtask
    task automatic fld(field_sel_t s, logic [7:0] v);
        @(posedge clk);
        field_wr <= 1;
        field_sel <= s;
        field_value <= v;
        @(posedge clk);
        field_wr <= 0;
        step(3);
    endtask
    task automatic walk(logic [7:0] v);
        for (int f = 0; f < 13; f++) begin
            fld(field_sel_t'(f), v);
            m = ((32'h1 << wid[f]) - 1) << lsb[f];
            exp = v[0] ? exp | m : exp & ~m;
            access(0, CTRL_ADDR, 0);
            chk(rd, exp);
        end
        step(20);
        chk(go, v[0]);
        chk({clk_cfg.ref_sel, loop_control, dclk_rst, txrx_rst,
            clk_cfg.feedback_en, clk_cfg.delay_en, clk_cfg.delay_taps,
            mapper_cfg.parity_invert, mapper_cfg.swap_sel,
            mapper_cfg.dll_disable, mapper_cfg.width_select},
            {24{v[0]}});
    endtask
    task automatic cmd(play_cmd_t c);
        @(posedge clk);
        play_cmd_valid <= 1;
        play_cmd <= c;
        @(posedge clk);
        play_cmd_valid <= 0;
        step(3);
    endtask
    task automatic pbuf(logic [31:0] a, logic [31:0] b);
        @(posedge clk);
        play_buf_wr <= 1;
        play_addr <= a;
        play_bytes <= b;
        @(posedge clk);
        play_buf_wr <= 0;
        step(3);
    endtask
    task automatic led_count();
        n = 0;
        repeat (16) @(posedge clk) n += (perr_led === 1'b1);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        #200_000;
        err_count++;
        end_of_test();
    end
    initial begin
        step(8);
        rst_n <= 1;
        step(3);
        exp = 32'hE000_0000;
        access(0, CTRL_ADDR, 0);
        chk(rd, exp);
        chk(bank_delay, {5'd2, 5'd1, 5'd0, 5'd0});
        chk({clk_cfg.src, clk_cfg.feedback_en, clk_cfg.delay_taps,
            mapper_cfg.swap_sel}, {SRC_MEZZ, 12'h0});
        chk(mapper_cfg.mux_mode, MUX4);
        walk(8'hFF);
        walk(8'h00);
        for (int c = 0; c < 4; c++) begin
            fld(FLD_REFCLK, 8'(c));
            chk(clk_cfg.src, c == 2 ? 0 : c);
        end
        foreach (sw[i]) begin
            fld(FLD_SWAP, 8'(sw[i]));
            chk(mapper_cfg.swap_class, sw[i] inside {1, 2, 3} ? SWAP_8 :
                sw[i] inside {4, 8, 12} ? SWAP_32 :
                sw[i] inside {16, 32, 48} ? SWAP_128 : SWAP_NONE);
        end
        for (int c = 0; c < 8; c++) begin
            fld(FLD_DLL, 8'(c % 4));
            fld(FLD_WSEL, 8'(c / 4));
            chk({mapper_cfg.mux_mode, mapper_cfg.lane_en},
                c == 1 ? {MUX2_AC, 4'h5} : c == 2 ? {MUX2_BC, 4'h6} :
                c >= 4 ? {MUX4, 4'hF} : {MUX_OFF, 4'h0});
        end
        for (int b = 0; b < 4; b++) begin
            @(posedge clk);
            bank_wr <= 1;
            bank_num <= 2'(b);
            bank_value <= 5'(31 - b);
        end
        @(posedge clk);
        bank_wr <= 0;
        step(3);
        chk(bank_delay, {5'd28, 5'd29, 5'd30, 5'd31});
        access(0, BANK_ADDR, 0);
        chk(rd, {12'h0, 5'd28, 5'd29, 5'd30, 5'd31});
        pbuf(32'h8000_0000, 32'h0008_0000);
        chk(play_out.base, 32'h8000_0000);
        chk(play_out.length, 32'h0008_0000);
        cmd(PLAY_START);
        chk(play_out.run, 1);
        pbuf(32'h1234_0000, 32'h100);
        chk(play_out.base, 32'h8000_0000);
        access(0, PLAY_STAT_ADDR, 0);
        chk(rd, 1);
        cmd(PLAY_STOP);
        chk(play_out.run, 0);
        cmd(PLAY_RESET);
        access(1, 32'h0000_0040, 32'hFFFF_FFFF);
        access(0, 32'h0000_0040, 0);
        chk(rd, 0);
        access(1, CTRL_ADDR, 32'hE000_0040);
        access(0, CTRL_ADDR, 0);
        chk(rd, 32'hE000_0040);
        perr_cmd <= 1;
        step(10);
        led_count();
        chk(n > 0 && n < 16, 1);
        access(0, STATUS_ADDR, 0);
        chk(rd, 32'h0000_0006);
        perr_cmd <= 0;
        step(10);
        led_count();
        chk(n > 0 && n < 16, 1);
        reset_button <= 1;
        step(8);
        reset_button <= 0;
        led_count();
        chk(n, 0);
        pmode <= 0;
        led_count();
        chk(n > 0 && n < 16, 1);
        end_of_test();
    end
endmodule
